/* File: core/dio_cpu_scan.sv */
/*
  Digital I/O scan of the base processor module: three conditioned
  inputs, five output relays and the system-fault relay.
  Assumes field inputs are asynchronous and the protection logic supplies
  output demands and the fault level on mclk.
*/
// What this block does
// - Sample every input once each 5 ms program cycle.
// - Per-input polarity: normally open reads energized as 1, closed as 0.
// - Programmable pickup delay 0..1800 s in 1 ms steps before 0 to 1.
// - Programmable release delay 0..1800 s in 1 ms steps before 1 to 0.
// - AC mode adds 30 ms to the release delay.
// - Output relay drives update once per 5 ms cycle.
// - Inputs reach internal logic one cycle after the status update.
// - Directly routed inputs reach outputs one further cycle later, up to 20 ms.
// - Fault relay rests unless powered without a system fault.
module dio_cpu_scan #(
  // Clock cycles per 1 ms tick; a bench may shorten it, scan ratios stay fixed
  parameter int unsigned CYC_PER_MS = dio_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                                  mclk,
  input  wire logic                                  rstn,
  // Field inputs
  input  wire logic [dio_pkg::NUM_INPUTS-1:0]        digital_input_n,
  // Input settings
  input  wire logic [dio_pkg::NUM_INPUTS-1:0]        input_sense_polarity,
  input  wire logic [dio_pkg::NUM_INPUTS-1:0]        alternating_input_release_extend,
  input  wire logic [dio_pkg::NUM_INPUTS*dio_pkg::DELAY_W-1:0] input_pickup_delay,
  input  wire logic [dio_pkg::NUM_INPUTS*dio_pkg::DELAY_W-1:0] input_release_delay,
  // Protection logic side
  input  wire logic [dio_pkg::NUM_OUTPUTS-1:0]       output_demand,
  input  wire logic [dio_pkg::NUM_INPUTS-1:0]        input_to_output_route,
  input  wire logic [dio_pkg::NUM_INPUTS*dio_pkg::NUM_OUTPUTS-1:0] route_map,
  input  wire logic                                  system_fault,
  output logic [dio_pkg::NUM_INPUTS-1:0]             input_status,
  output logic [dio_pkg::NUM_INPUTS-1:0]             logic_input,
  output logic                                       scan_strobe,
  // Relays
  output logic [dio_pkg::NUM_OUTPUTS-1:0]            relay_output_n,
  output logic                                       fault_relay_energize
);
  dio_tick_if tick ();

  logic [dio_pkg::MS_CNT_W-1:0]     ms_cnt_ff;
  logic [dio_pkg::CYC_CNT_W-1:0]    cyc_cnt_ff;
  logic                             ms_tick_ff;
  logic                             scan_tick_ff;
  logic [dio_pkg::NUM_INPUTS-1:0]   sync1_ff;
  logic [dio_pkg::NUM_INPUTS-1:0]   sync2_ff;
  logic [dio_pkg::NUM_INPUTS-1:0]   sync3_ff;
  logic [dio_pkg::NUM_INPUTS-1:0]   stable_ff;
  logic [dio_pkg::NUM_INPUTS-1:0]   chan_status;
  logic [dio_pkg::NUM_INPUTS-1:0]   status_ff;
  logic [dio_pkg::NUM_INPUTS-1:0]   logic_ff;
  logic [dio_pkg::NUM_OUTPUTS-1:0]  relay_ff;
  logic [dio_pkg::NUM_OUTPUTS-1:0]  nxt_relay;
  logic                             fault_ff;
  logic                             strobe_ff;

  assign tick.ms_tick   = ms_tick_ff;
  assign tick.scan_tick = scan_tick_ff;

  // ---------------------------------------------------------------
  // 1 ms and 5 ms timebase
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ms_cnt_ff  <= '0;
      ms_tick_ff <= 1'b0;
    end else if (ms_cnt_ff == dio_pkg::MS_CNT_W'(CYC_PER_MS - 1)) begin
      ms_cnt_ff  <= '0;
      ms_tick_ff <= 1'b1;
    end else begin
      ms_cnt_ff  <= ms_cnt_ff + 1'b1;
      ms_tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cyc_cnt_ff   <= '0;
      scan_tick_ff <= 1'b0;
    end else begin
      scan_tick_ff <= 1'b0;
      if (ms_tick_ff) begin
        if (cyc_cnt_ff == dio_pkg::CYC_CNT_W'(dio_pkg::CYCLE_MS - 1)) begin
          cyc_cnt_ff   <= '0;
          scan_tick_ff <= 1'b1;
        end else begin
          cyc_cnt_ff <= cyc_cnt_ff + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Change accepted only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_ff  <= '0;
      sync2_ff  <= '0;
      sync3_ff  <= '0;
      stable_ff <= '0;
    end else begin
      sync1_ff <= digital_input_n;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (int i = 0; i < dio_pkg::NUM_INPUTS; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) stable_ff[i] <= sync3_ff[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Input channels
  // ---------------------------------------------------------------
  for (genvar g = 0; g < dio_pkg::NUM_INPUTS; g++) begin : g_chan
    dio_input_chan u_chan (
      .mclk                             (mclk),
      .rstn                             (rstn),
      .tick                             (tick),
      .raw_sync                         (stable_ff[g]),
      .input_sense_polarity             (input_sense_polarity[g]),
      .alternating_input_release_extend (alternating_input_release_extend[g]),
      .input_pickup_delay               (input_pickup_delay[g*dio_pkg::DELAY_W +: dio_pkg::DELAY_W]),
      .input_release_delay              (input_release_delay[g*dio_pkg::DELAY_W +: dio_pkg::DELAY_W]),
      .status                           (chan_status[g])
    );
  end

  // ---------------------------------------------------------------
  // Program cycle pipeline
  // ---------------------------------------------------------------
  // Each stage moves once per scan so latency is whole 5 ms rounds
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      status_ff <= '0;
      logic_ff  <= '0;
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= scan_tick_ff;
      if (scan_tick_ff) begin
        status_ff <= chan_status;
        logic_ff  <= status_ff;
      end
    end
  end

  always_comb begin
    nxt_relay = output_demand;
    for (int i = 0; i < dio_pkg::NUM_INPUTS; i++) begin
      if (input_to_output_route[i] && logic_ff[i]) begin
        nxt_relay = nxt_relay | route_map[i*dio_pkg::NUM_OUTPUTS +: dio_pkg::NUM_OUTPUTS];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      relay_ff <= '0;
    end else if (scan_tick_ff) begin
      relay_ff <= nxt_relay;
    end
  end

  // Held de-energized in reset so the contact shows fault until running
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= !system_fault;
    end
  end

  assign input_status         = status_ff;
  assign logic_input          = logic_ff;
  assign scan_strobe          = strobe_ff;
  assign relay_output_n       = relay_ff;
  assign fault_relay_energize = fault_ff;
endmodule : dio_cpu_scan

/* File: core/dio_pkg.sv */
/*
  Package of the digital input scan block: timing counts, channel counts,
  delay field widths and reset values.
  Assumes a 50 MHz mclk and a 5 ms program cycle.
*/
package dio_pkg;
  // ---------------------------------------------------------------
  // Channel counts
  // ---------------------------------------------------------------
  localparam int unsigned NUM_INPUTS  = 3;
  localparam int unsigned NUM_OUTPUTS = 5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_MS_US    = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1_000_000 * TICK_MS_US;
  localparam int unsigned CYCLE_MS      = 5;
  localparam int unsigned AC_EXTEND_MS  = 30;
  localparam int unsigned DELAY_MAX_MS  = 1_800_000;
  localparam int unsigned MS_CNT_W      = 16;
  localparam int unsigned CYC_CNT_W     = 3;
  localparam int unsigned DELAY_W       = 21;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [DELAY_W-1:0] DELAY_RST  = 21'h00_0000;
  localparam logic               POL_NO     = 1'b0;
  localparam logic               POL_NC     = 1'b1;
  localparam logic               STATUS_RST = 1'b0;

  // ---------------------------------------------------------------
  // Per-channel delay timer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DIO_IDLE   = 2'b00,
    DIO_PICKUP = 2'b01,
    DIO_RELEASE = 2'b10
  } dio_tmr_t;
endpackage : dio_pkg

/* File: core/dio_tick_if.sv */
/*
  Interface carrying the scan timebase from the top to each input channel.
  Assumes one driver (the top) and any number of channel readers.
*/
interface dio_tick_if;
  logic ms_tick;
  logic scan_tick;
  modport src (output ms_tick, output scan_tick);
  modport dst (input ms_tick, input scan_tick);
endinterface : dio_tick_if

/* File: core/dio_input_chan.sv */
/*
  One conditioned digital input: polarity, pickup and release delays,
  optional AC release extension, sampled on the scan tick.
  Assumes raw_sync is already synchronised to mclk.
*/
module dio_input_chan (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  // Timebase
  dio_tick_if.dst                          tick,
  // Field level and settings
  input  wire logic                        raw_sync,
  input  wire logic                        input_sense_polarity,
  input  wire logic                        alternating_input_release_extend,
  input  wire logic [dio_pkg::DELAY_W-1:0] input_pickup_delay,
  input  wire logic [dio_pkg::DELAY_W-1:0] input_release_delay,
  // Status
  output logic                             status
);
  logic                          sample_ff;
  logic                          status_ff;
  logic [dio_pkg::DELAY_W-1:0]   cnt_ff;
  dio_pkg::dio_tmr_t             st_ff;
  logic [dio_pkg::DELAY_W-1:0]   rel_target;

  assign status = status_ff;
  assign rel_target = alternating_input_release_extend
    ? input_release_delay + dio_pkg::DELAY_W'(dio_pkg::AC_EXTEND_MS)
    : input_release_delay;

  // ---------------------------------------------------------------
  // Scan sample with polarity
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sample_ff <= dio_pkg::STATUS_RST;
    end else if (tick.scan_tick) begin
      sample_ff <= raw_sync ^ (input_sense_polarity == dio_pkg::POL_NC);
    end
  end

  // ---------------------------------------------------------------
  // Delay timer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff     <= dio_pkg::DIO_IDLE;
      cnt_ff    <= dio_pkg::DELAY_RST;
      status_ff <= dio_pkg::STATUS_RST;
    end else begin
      unique case (st_ff)
        dio_pkg::DIO_IDLE: begin
          cnt_ff <= dio_pkg::DELAY_RST;
          if (sample_ff && !status_ff) begin
            if (input_pickup_delay == dio_pkg::DELAY_RST) status_ff <= 1'b1;
            else st_ff <= dio_pkg::DIO_PICKUP;
          end else if (!sample_ff && status_ff) begin
            if (rel_target == dio_pkg::DELAY_RST) status_ff <= 1'b0;
            else st_ff <= dio_pkg::DIO_RELEASE;
          end
        end
        dio_pkg::DIO_PICKUP: begin
          if (!sample_ff) begin
            st_ff <= dio_pkg::DIO_IDLE;
          end else if (tick.ms_tick) begin
            if (cnt_ff + 1'b1 >= input_pickup_delay) begin
              status_ff <= 1'b1;
              st_ff     <= dio_pkg::DIO_IDLE;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
        end
        dio_pkg::DIO_RELEASE: begin
          if (sample_ff) begin
            st_ff <= dio_pkg::DIO_IDLE;
          end else if (tick.ms_tick) begin
            if (cnt_ff + 1'b1 >= rel_target) begin
              status_ff <= 1'b0;
              st_ff     <= dio_pkg::DIO_IDLE;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
        end
        default: st_ff <= dio_pkg::DIO_IDLE;
      endcase
    end
  end
endmodule : dio_input_chan

/* File: tb/dio_field_model.sv */
/*
  Field wiring model: drives the three raw inputs from a wanted level,
  with a short contact chatter after each change.
  Assumes the bench changes the wanted level well away from a scan tick.
*/
module dio_field_model (
  // Clock
  input  wire logic       mclk,
  // Wanted level and field side
  input  wire logic [2:0] lvl,
  output logic [2:0]      digital_input_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last = 3'h0;
  logic [2:0] chatter = 3'h0;
  // Real contacts bounce; the synchroniser and scan must not pass it on
  always @(posedge mclk) begin
    last <= lvl;
    chatter <= (lvl != last) ? 3'h5 : chatter - {2'h0, chatter != 3'h0};
    digital_input_n <= chatter[0] ? ~lvl : lvl;
  end
endmodule : dio_field_model

/* File: tb/dio_cpu_scan_checker.sv */
/*
  Checker of the digital I/O scan: strobe spacing, update moments,
  relay value, fault relay and reset. Assumes a bind to dio_cpu_scan.
*/
module dio_cpu_scan_checker #(
  parameter int unsigned CYC_PER_MS = dio_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // Protection logic side
  input wire logic [4:0]  output_demand,
  input wire logic [2:0]  input_to_output_route,
  input wire logic [14:0] route_map,
  input wire logic        system_fault,
  // Outputs
  input wire logic [2:0]  input_status,
  input wire logic [2:0]  logic_input,
  input wire logic        scan_strobe,
  input wire logic [4:0]  relay_output_n,
  input wire logic        fault_relay_energize
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles between strobes, less the strobe cycle itself
  localparam logic [17:0] SCAN_GAP = 18'(dio_pkg::CYCLE_MS * CYC_PER_MS - 1);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [17:0] gap;
  logic        seen;
  logic        rst_q;
  logic [4:0]  exp_rel;
  always_ff @(posedge mclk) begin
    rst_q <= !rstn;
    seen  <= rstn && (seen || scan_strobe);
    gap   <= (!rstn || scan_strobe) ? 18'h0_0000 : gap + 18'h0_0001;
  end
  // Routed inputs are ORed onto the demand
  always_comb begin
    exp_rel = output_demand;
    for (int i = 0; i < 3; i++) begin
      if (input_to_output_route[i] && logic_input[i]) begin
        exp_rel = exp_rel | route_map[i*5+:5];
      end
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_strobe_period; seen |-> (scan_strobe ? gap == SCAN_GAP : gap < SCAN_GAP); endproperty
  a_strobe_period: assert property (p_strobe_period) else $error("scan spacing off");
  property p_strobe_single; scan_strobe |=> !scan_strobe [*8]; endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("strobe too long");
  property p_status_moment; $changed(input_status) |-> scan_strobe; endproperty
  a_status_moment: assert property (p_status_moment) else $error("status off scan");
  property p_logic_delay; scan_strobe |-> logic_input == $past(input_status); endproperty
  a_logic_delay: assert property (p_logic_delay) else $error("logic input lag");
  property p_logic_moment; $changed(logic_input) |-> scan_strobe; endproperty
  a_logic_moment: assert property (p_logic_moment) else $error("logic off scan");
  property p_relay_value; scan_strobe |-> relay_output_n == $past(exp_rel); endproperty
  a_relay_value: assert property (p_relay_value) else $error("relay value");
  property p_relay_moment; $changed(relay_output_n) |-> scan_strobe; endproperty
  a_relay_moment: assert property (p_relay_moment) else $error("relay off scan");
  property p_fault_follow; $past(rstn) |-> fault_relay_energize == !$past(system_fault); endproperty
  a_fault_follow: assert property (p_fault_follow) else $error("fault relay");
  property p_reset_clear; rst_q |-> {input_status, logic_input, relay_output_n, fault_relay_energize} == 12'h000; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state");
  c_status: cover property (scan_strobe && input_status != 3'h0);
  c_routed: cover property (scan_strobe && relay_output_n != $past(output_demand));
  c_fault: cover property ($fell(fault_relay_energize));
endmodule : dio_cpu_scan_checker
bind dio_cpu_scan dio_cpu_scan_checker #(.CYC_PER_MS(CYC_PER_MS)) i_dio_cpu_scan_checker (.mclk, .rstn,
  .output_demand, .input_to_output_route, .route_map, .system_fault, .input_status, .logic_input, .scan_strobe,
  .relay_output_n, .fault_relay_energize);

/* File: tb/dio_cpu_scan_tb.sv */
/*
  Bench of the digital I/O scan: a table of polarity, demand and fault
  cases, then latency, delay, AC release and reset tests.
  Assumes the checker is bound in and the field model drives the inputs.
*/
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
module dio_cpu_scan_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Shortened ms tick keeps the run brief; all delays stay in ms ticks
  localparam int unsigned TB_CYC_PER_MS = 20;
  typedef struct packed {
    logic [2:0] din, pol;
    logic [4:0] dem;
    logic       sf;
    logic [2:0] st;
    logic [4:0] rel;
    logic       flt;
  } dio_row_t;
  // Relay equals demand while routing is off
  dio_row_t    rows [4] = '{'{3'h0, 3'h0, 5'h00, 1'b0, 3'h0, 5'h00, 1'b1},
                            '{3'h5, 3'h0, 5'h15, 1'b1, 3'h5, 5'h15, 1'b0},
                            '{3'h5, 3'h6, 5'h0a, 1'b0, 3'h3, 5'h0a, 1'b1},
                            '{3'h2, 3'h7, 5'h1f, 1'b1, 3'h5, 5'h1f, 1'b0}};
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        sf = 1'b0;
  logic        scan_strobe, fault_relay_energize;
  logic [2:0]  lvl = 3'h0, pol = 3'h0, ac = 3'h0, route = 3'h0;
  logic [2:0]  digital_input_n, input_status, logic_input;
  logic [4:0]  dem = 5'h00;
  logic [4:0]  relay_output_n;
  logic [14:0] rmap = 15'h0000;
  logic [62:0] pick = 63'h0, rls = 63'h0;
  int          error_cnt = 0, compares = 0;
  dio_field_model i_dio_field_model (.mclk, .lvl, .digital_input_n);
  dio_cpu_scan #(.CYC_PER_MS(TB_CYC_PER_MS)) i_dio_cpu_scan (.mclk, .rstn, .digital_input_n, .input_sense_polarity(pol),
    .alternating_input_release_extend(ac), .input_pickup_delay(pick), .input_release_delay(rls),
    .output_demand(dem), .input_to_output_route(route), .route_map(rmap), .system_fault(sf),
    .input_status, .logic_input, .scan_strobe, .relay_output_n, .fault_relay_energize);
  initial forever #10 mclk = ~mclk;
  // Stops just after the n-th strobe, when outputs have settled
  task automatic scan(int n);
    repeat (n) do @(negedge mclk); while (scan_strobe !== 1'b1);
  endtask : scan
  task automatic stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // Whole run is about 30 scans of 100 cycles each
  initial begin
    #150us;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge mclk);
      {lvl, pol, dem, sf} <= {rows[i].din, rows[i].pol, rows[i].dem, rows[i].sf};
      scan(2);
      `CHK("status", rows[i].st, input_status)
      `CHK("relay", rows[i].rel, relay_output_n)
      `CHK("fault", rows[i].flt, fault_relay_energize)
    end
    // Input 0 routed to relays 1 and 4: relay follows on the fourth scan
    @(posedge mclk);
    {lvl, pol, dem, sf} <= 12'h000;
    scan(2);
    @(posedge mclk);
    {route, rmap, lvl} <= {3'h1, 15'h0012, 3'h1};
    scan(1);
    `CHK("status", 3'h0, input_status)
    scan(1);
    `CHK("status", 3'h1, input_status)
    `CHK("logic", 3'h0, logic_input)
    scan(1);
    `CHK("logic", 3'h1, logic_input)
    `CHK("relay", 5'h00, relay_output_n)
    scan(1);
    `CHK("relay", 5'h12, relay_output_n)
    // Input 1 with 12 ms delays, input 2 with AC release
    @(posedge mclk);
    {route, ac, lvl} <= {3'h0, 3'h4, 3'h6};
    pick <= {21'h00_0000, 21'h00_000c, 21'h00_0000};
    rls <= {21'h00_0000, 21'h00_000c, 21'h00_0000};
    scan(2);
    `CHK("status", 3'h4, input_status)
    scan(1);
    `CHK("status", 3'h4, input_status)
    scan(1);
    `CHK("status", 3'h6, input_status)
    @(posedge mclk);
    lvl <= 3'h0;
    scan(1);
    @(posedge mclk);
    lvl <= 3'h2;
    scan(1);
    @(posedge mclk);
    lvl <= 3'h0;
    scan(3);
    `CHK("status", 3'h6, input_status)
    scan(1);
    `CHK("status", 3'h4, input_status)
    scan(2);
    `CHK("status", 3'h0, input_status)
    // Reset in mid-run with relays driven
    @(posedge mclk);
    dem <= 5'h1f;
    scan(1);
    `CHK("relay", 5'h1f, relay_output_n)
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(negedge mclk);
    `CHK("reset", 13'h0000, {input_status, logic_input, relay_output_n, scan_strobe, fault_relay_energize})
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(negedge mclk);
    `CHK("fault", 1'b1, fault_relay_energize)
    stop_test();
  end
endmodule : dio_cpu_scan_tb
